/* common/cst_pkg.sv */
// register map, field layout and reset constants for the tonemap register bank
package cst_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 16;
    localparam int          THR_W           = 12;
    localparam int          TABLE_DEPTH     = 512;
    localparam int          TABLE_AW        = 9;
    // register offsets
    localparam logic [7:0]  OFF_VIDEO       = 8'h0D;
    localparam logic [7:0]  OFF_INTEG       = 8'h0E;
    localparam logic [7:0]  OFF_VER_RST     = 8'h0F;
    localparam logic [7:0]  OFF_SWITCH      = 8'h11;
    localparam logic [7:0]  OFF_CTRL_A      = 8'h13;
    localparam logic [7:0]  OFF_CTRL_B      = 8'h14;
    localparam logic [7:0]  OFF_TABLE       = 8'h15;
    // field positions
    localparam int          POS_GAMMA_LO    = 8;
    localparam int          POS_VER_LO      = 1;
    localparam int          POS_SOFT_RST    = 0;
    localparam int          POS_DEC_LO      = 12;
    localparam int          POS_ENABLE      = 15;
    localparam int          POS_TABLE_SEL   = 13;
    localparam int          POS_GEN_SEL     = 12;
    // limits and reset values
    localparam logic [11:0] INTEG_MAX       = 12'hF30;
    localparam logic [15:0] CTRL_A_RST      = 16'h0000;
    localparam logic [15:0] CTRL_B_RST      = 16'h0000;
    localparam logic [8:0]  TABLE_PTR_RST   = 9'h000;
    // firmware version, value arbitrary
    localparam logic [5:0]  FW_VERSION      = 6'h01;
endpackage

/* design/cst_regs.sv */
// register bank: status readback, soft reset and tonemap curve generation
`timescale 1ns/1ps
module cst_regs #(
    parameter int TABLE_DEPTH = cst_pkg::TABLE_DEPTH
) (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        clk_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic [4:0]  aec_gamma,
    input  wire logic [7:0]  aec_average,
    input  wire logic [11:0] aec_integration,
    input  wire logic        aec_update,
    input  wire logic        frame_start,
    input  wire logic [7:0]  switch_in,
    input  wire logic [8:0]  gray_level,
    output logic      [11:0] threshold_out,
    output logic             tonemap_enable,
    output logic             soft_reset_pulse
);
    logic [4:0]  gamma_reg;
    logic [7:0]  average_reg;
    logic [11:0] integ_reg;
    logic        integ_done_reg;
    logic [7:0]  switch_reg;
    logic [15:0] ctrl_a_reg;
    logic [15:0] ctrl_b_reg;
    logic [8:0]  tbl_ptr_reg;
    logic [11:0] tbl_mem [TABLE_DEPTH];
    logic [11:0] tbl_rd_reg;
    logic [11:0] gen_next;
    logic [11:0] thr_next;
    logic [15:0] rdata_next;
    logic        wr_ctrl;
    logic        any_rst;
    logic [11:0] start_val;
    logic [11:0] floor_val;
    logic [2:0]  dec_val;
    logic [20:0] drop;

    assign start_val = ctrl_a_reg[cst_pkg::THR_W-1:0];
    assign dec_val   = ctrl_a_reg[cst_pkg::POS_DEC_LO +: 3];
    assign floor_val = ctrl_b_reg[cst_pkg::THR_W-1:0];
    assign wr_ctrl   = clk_en && reg_wr;
    // soft reset acts like power-on for the status, control, pointer and output registers, not for reg_rdata, soft_reset_pulse or the table
    assign any_rst   = srst || (wr_ctrl && reg_addr == cst_pkg::OFF_VER_RST
                       && reg_wdata[cst_pkg::POS_SOFT_RST]);

    // soft reset strobe for the rest of the pipeline
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            soft_reset_pulse <= 1'b0;
        else if (clk_en)
            soft_reset_pulse <= any_rst && !srst;
    end

    // gamma and average follow the exposure loop immediately
    always_ff @(posedge clk_sys)
    begin
        if (any_rst)
        begin
            gamma_reg   <= 5'h00;
            average_reg <= 8'h00;
        end
        else if (clk_en && aec_update)
        begin
            gamma_reg   <= aec_gamma;
            average_reg <= aec_average;
        end
    end

    // integration value, clamped, captured once per frame
    always_ff @(posedge clk_sys)
    begin
        if (any_rst)
        begin
            integ_reg      <= 12'h000;
            integ_done_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            // an update in the frame_start cycle counts for the new frame
            if (aec_update && (!integ_done_reg || frame_start))
            begin
                integ_reg <= (aec_integration > cst_pkg::INTEG_MAX)
                             ? cst_pkg::INTEG_MAX : aec_integration;
                integ_done_reg <= 1'b1;
            end
            else if (frame_start)
                integ_done_reg <= 1'b0;
        end
    end

    // switch sampling register
    always_ff @(posedge clk_sys)
    begin
        if (any_rst)
            switch_reg <= 8'h00;
        else if (clk_en)
            switch_reg <= switch_in;
    end

    // curve control registers
    always_ff @(posedge clk_sys)
    begin
        if (any_rst)
        begin
            ctrl_a_reg <= cst_pkg::CTRL_A_RST;
            ctrl_b_reg <= cst_pkg::CTRL_B_RST;
        end
        else if (wr_ctrl)
        begin
            if (reg_addr == cst_pkg::OFF_CTRL_A)
                ctrl_a_reg <= {1'b0, reg_wdata[14:0]};
            if (reg_addr == cst_pkg::OFF_CTRL_B)
                ctrl_b_reg <= {reg_wdata[15], 1'b0, reg_wdata[13:0]};
        end
    end

    // table write pointer restarts at zero after any reset
    always_ff @(posedge clk_sys)
    begin
        if (any_rst)
            tbl_ptr_reg <= cst_pkg::TABLE_PTR_RST;
        else if (wr_ctrl && reg_addr == cst_pkg::OFF_TABLE)
            tbl_ptr_reg <= tbl_ptr_reg + 9'h001;
    end

    // table storage, one entry per gray level
    always_ff @(posedge clk_sys)
    begin
        if (wr_ctrl && reg_addr == cst_pkg::OFF_TABLE)
            tbl_mem[tbl_ptr_reg] <= reg_wdata[11:0];
        if (clk_en)
            tbl_rd_reg <= tbl_mem[gray_level];
    end

    // slope curve: start minus gray times decrement, floored
    always_comb
    begin
        drop = 21'(gray_level) * 21'(dec_val);
        if (floor_val >= start_val)
            gen_next = floor_val;
        else if (drop >= 21'(start_val - floor_val))
            gen_next = floor_val;
        else
            gen_next = start_val - drop[11:0];
    end

    // curve source selection
    always_comb
    begin
        if (ctrl_b_reg[cst_pkg::POS_TABLE_SEL])
            thr_next = tbl_rd_reg;
        else if (ctrl_b_reg[cst_pkg::POS_GEN_SEL])
            thr_next = gen_next;
        else
            thr_next = 12'h000;
    end

    // tonemap outputs registered
    always_ff @(posedge clk_sys)
    begin
        if (any_rst)
        begin
            threshold_out  <= 12'h000;
            tonemap_enable <= 1'b0;
        end
        else if (clk_en)
        begin
            threshold_out  <= thr_next;
            tonemap_enable <= ctrl_b_reg[cst_pkg::POS_ENABLE];
        end
    end

    // read data mux
    always_comb
    begin
        rdata_next = 16'h0000;
        unique case (reg_addr)
            cst_pkg::OFF_VIDEO:
                rdata_next = {3'h0, gamma_reg, average_reg};
            cst_pkg::OFF_INTEG:
                rdata_next = {4'h0, integ_reg};
            cst_pkg::OFF_VER_RST:
                rdata_next = {9'h000, cst_pkg::FW_VERSION, 1'b0};
            cst_pkg::OFF_SWITCH:
                rdata_next = {8'h00, switch_reg};
            cst_pkg::OFF_CTRL_A:
                rdata_next = ctrl_a_reg;
            cst_pkg::OFF_CTRL_B:
                rdata_next = ctrl_b_reg;
            default:
                rdata_next = 16'h0000;
        endcase
    end

    // read data register, captured on a read strobe
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            reg_rdata <= 16'h0000;
        else if (clk_en && reg_rd)
            reg_rdata <= rdata_next;
    end

    // exposure status checks: capture one cycle after an update, integration limit, one capture per frame
    chk_gamma_follow: assert property (
        @(posedge clk_sys) disable iff (srst)
        clk_en && aec_update && !any_rst |=> gamma_reg == $past(aec_gamma))
        else $error("gamma not captured");
    chk_average_follow: assert property (
        @(posedge clk_sys) disable iff (srst)
        clk_en && aec_update && !any_rst
        |=> average_reg == $past(aec_average))
        else $error("average not captured");
    chk_integ_take: assert property (
        @(posedge clk_sys) disable iff (srst)
        clk_en && aec_update && !integ_done_reg && !any_rst
        && aec_integration <= cst_pkg::INTEG_MAX
        |=> integ_reg == $past(aec_integration))
        else $error("integration not captured");
    chk_integ_max: assert property (
        @(posedge clk_sys) disable iff (srst)
        integ_reg <= cst_pkg::INTEG_MAX)
        else $error("integration above limit");
    chk_integ_once: assert property (
        @(posedge clk_sys) disable iff (srst)
        integ_done_reg && !frame_start && !any_rst |=> $stable(integ_reg))
        else $error("integration updated twice in frame");

    // soft reset checks
    chk_soft_reset: assert property (
        @(posedge clk_sys) disable iff (srst)
        any_rst |=> ctrl_b_reg == cst_pkg::CTRL_B_RST
                    && tbl_ptr_reg == cst_pkg::TABLE_PTR_RST)
        else $error("soft reset did not clear");
    chk_status_clear: assert property (
        @(posedge clk_sys) disable iff (srst)
        any_rst |=> gamma_reg == 5'h00 && average_reg == 8'h00
                    && integ_reg == 12'h000
                    && ctrl_a_reg == cst_pkg::CTRL_A_RST)
        else $error("soft reset left status set");
    chk_pulse_cause: assert property (
        @(posedge clk_sys) disable iff (srst)
        any_rst |=> soft_reset_pulse)
        else $error("soft reset strobe missing");

    // slope curve checks
    chk_floor_hold: assert property (
        @(posedge clk_sys) disable iff (srst)
        gen_next >= floor_val)
        else $error("curve below floor");
    chk_gray_zero: assert property (
        @(posedge clk_sys) disable iff (srst)
        gray_level == 9'h000 && start_val > floor_val
        |-> gen_next == start_val)
        else $error("gray zero not at start");
    chk_flat_curve: assert property (
        @(posedge clk_sys) disable iff (srst)
        floor_val >= start_val |-> gen_next == floor_val)
        else $error("flat curve not at floor");
    chk_slope_value: assert property (
        @(posedge clk_sys) disable iff (srst)
        start_val > floor_val && gen_next > floor_val
        |-> 21'(gen_next) + 21'(gray_level) * 21'(dec_val) == 21'(start_val))
        else $error("slope not cumulative");

    // table pointer and curve source checks
    chk_table_step: assert property (
        @(posedge clk_sys) disable iff (srst)
        wr_ctrl && reg_addr == cst_pkg::OFF_TABLE && !any_rst
        |=> tbl_ptr_reg == $past(tbl_ptr_reg) + 9'h001)
        else $error("table pointer did not step");
    chk_table_hold: assert property (
        @(posedge clk_sys) disable iff (srst)
        !any_rst && !(wr_ctrl && reg_addr == cst_pkg::OFF_TABLE)
        |=> $stable(tbl_ptr_reg))
        else $error("table pointer moved without a write");
    chk_table_select: assert property (
        @(posedge clk_sys) disable iff (srst)
        clk_en && !any_rst && ctrl_b_reg[cst_pkg::POS_TABLE_SEL]
        |=> threshold_out == $past(tbl_rd_reg))
        else $error("table curve not selected");
    chk_gen_select: assert property (
        @(posedge clk_sys) disable iff (srst)
        clk_en && !any_rst && !ctrl_b_reg[cst_pkg::POS_TABLE_SEL]
        && ctrl_b_reg[cst_pkg::POS_GEN_SEL]
        |=> threshold_out == $past(gen_next))
        else $error("generated curve not selected");
    chk_enable_out: assert property (
        @(posedge clk_sys) disable iff (srst)
        clk_en && !any_rst |=> tonemap_enable == $past(ctrl_b_reg[15]))
        else $error("enable not forwarded");

    // register readback checks, data one cycle after the read strobe
    chk_video_read: assert property (
        @(posedge clk_sys) disable iff (srst)
        clk_en && reg_rd && reg_addr == cst_pkg::OFF_VIDEO
        |=> reg_rdata == {3'h0, $past(gamma_reg), $past(average_reg)})
        else $error("video status readback wrong");
    chk_integ_read: assert property (
        @(posedge clk_sys) disable iff (srst)
        clk_en && reg_rd && reg_addr == cst_pkg::OFF_INTEG
        |=> reg_rdata == {4'h0, $past(integ_reg)})
        else $error("integration readback wrong");
    chk_version_read: assert property (
        @(posedge clk_sys) disable iff (srst)
        clk_en && reg_rd && reg_addr == cst_pkg::OFF_VER_RST
        |=> reg_rdata == {9'h000, cst_pkg::FW_VERSION, 1'b0})
        else $error("version readback wrong");
    chk_switch_read: assert property (
        @(posedge clk_sys) disable iff (srst)
        clk_en && reg_rd && reg_addr == cst_pkg::OFF_SWITCH
        |=> reg_rdata == {8'h00, $past(switch_reg)})
        else $error("switch readback wrong");

    // main scenarios
    cov_table_mode: cover property (@(posedge clk_sys)
        ctrl_b_reg[cst_pkg::POS_TABLE_SEL] && tonemap_enable);
    cov_gen_mode: cover property (@(posedge clk_sys)
        ctrl_b_reg[cst_pkg::POS_GEN_SEL] && gen_next == floor_val);
    cov_flat_curve: cover property (@(posedge clk_sys)
        ctrl_b_reg[cst_pkg::POS_GEN_SEL] && floor_val > start_val);
    cov_integ_clamp: cover property (@(posedge clk_sys)
        aec_update && !integ_done_reg && aec_integration > cst_pkg::INTEG_MAX);
    cov_soft_reset: cover property (@(posedge clk_sys)
        soft_reset_pulse);
endmodule

/* testbench/cst_host_model.sv */
// host model driving the register bank access strobes
`timescale 1ns/1ps
module cst_host_model (
    input  wire logic        clk_sys,
    output logic      [7:0]  reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [15:0] reg_rdata
);
    // idle bus at time zero
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one-cycle write strobe launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1 reg_wr = 1'b0;
        reg_wdata = ~d; // stale data does not linger
    endtask
    // one-cycle read strobe, data taken after the answer edge
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        #1 reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_sys);
        #1 reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    // read twice and once more if the two disagree
    task automatic rd_twice(input logic [7:0] a, output logic [15:0] d);
        logic [15:0] p;
        rd(a, p);
        rd(a, d);
        if (p !== d)
            rd(a, d);
    endtask
endmodule

/* testbench/cst_regs_tb.sv */
// self-checking bench for the tonemap register bank
`timescale 1ns/1ps
module cst_regs_tb;
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic [15:0] rdata;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic [4:0]  aec_gamma = 5'h00;
    logic [7:0]  aec_average = 8'h00;
    logic [11:0] aec_integration = 12'h000;
    logic        aec_update = 1'b0;
    logic        frame_start = 1'b0;
    logic [7:0]  switch_in = 8'h5A;
    logic [8:0]  gray_level = 9'h000;
    logic [11:0] threshold_out;
    logic        tonemap_enable;
    logic        soft_reset_pulse;
    logic        clk_en = 1'b1;
    int          error_cnt = 0;
    int          total_checks = 0;
    // 40 MHz system clock
    always #12.5 clk_sys = ~clk_sys;
    cst_regs DUT (.clk_sys, .srst, .clk_en, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .aec_gamma, .aec_average,
        .aec_integration, .aec_update, .frame_start, .switch_in,
        .gray_level, .threshold_out, .tonemap_enable, .soft_reset_pulse);
    cst_host_model host (.clk_sys, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata);
    // value comparison
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // read a register and compare
    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        host.rd(a, rdata);
        chk(rdata, e);
    endtask
    // ask for one gray level and compare its threshold
    task automatic tc(input logic [8:0] g, input logic [11:0] e);
        @(posedge clk_sys);
        #1 gray_level = g;
        repeat (3) @(posedge clk_sys);
        #1 chk({4'h0, threshold_out}, {4'h0, e});
    endtask
    // one-cycle exposure loop result or frame pulse
    task automatic au(input logic u, input logic [11:0] i);
        @(posedge clk_sys);
        #1 aec_integration = i;
        aec_update = u;
        frame_start = !u;
        @(posedge clk_sys);
        #1 aec_update = 1'b0;
        frame_start = 1'b0;
    endtask
    // verdict and end of run
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        complete_run();
    end
    // main sequence
    initial
    begin
        repeat (4) @(posedge clk_sys);
        #1 srst = 1'b0;
        rc(cst_pkg::OFF_CTRL_A, cst_pkg::CTRL_A_RST);
        rc(8'h12, 16'h0000);
        chk({4'h0, threshold_out}, 16'h0000);
        $display("test reset done");
        aec_gamma = 5'h15;
        aec_average = 8'hA5;
        au(1'b0, 12'h000);
        au(1'b1, 12'h123);
        rc(cst_pkg::OFF_VIDEO, 16'h15A5);
        host.rd_twice(cst_pkg::OFF_INTEG, rdata);
        chk(rdata, 16'h0123);
        au(1'b1, 12'hFFF);
        rc(cst_pkg::OFF_INTEG, 16'h0123);
        au(1'b0, 12'h000);
        au(1'b1, 12'hFFF);
        rc(cst_pkg::OFF_INTEG, 16'h0F30);
        host.wr(cst_pkg::OFF_VIDEO, 16'hFFFF);
        rc(cst_pkg::OFF_VIDEO, 16'h15A5);
        rc(cst_pkg::OFF_VER_RST, {9'h0, cst_pkg::FW_VERSION, 1'b0});
        rc(cst_pkg::OFF_SWITCH, 16'h005A);
        switch_in = 8'hC3;
        rc(cst_pkg::OFF_SWITCH, 16'h00C3);
        $display("test status done");
        host.wr(cst_pkg::OFF_CTRL_A, 16'h3100);
        host.wr(cst_pkg::OFF_CTRL_B, 16'h90F0);
        rc(cst_pkg::OFF_CTRL_B, 16'h90F0);
        chk({15'h0, tonemap_enable}, 16'h0001);
        tc(9'h000, 12'h100);
        tc(9'h002, 12'h0FA);
        tc(9'h005, 12'h0F1);
        tc(9'h006, 12'h0F0);
        tc(9'h12C, 12'h0F0);
        host.wr(cst_pkg::OFF_CTRL_B, 16'h9200);
        tc(9'h000, 12'h200);
        tc(9'h064, 12'h200);
        $display("test curve done");
        host.wr(cst_pkg::OFF_TABLE, 16'h0777);
        host.wr(cst_pkg::OFF_VER_RST, 16'h0001);
        chk({15'h0, soft_reset_pulse}, 16'h0001);
        rc(cst_pkg::OFF_CTRL_A, 16'h0000);
        chk({15'h0, tonemap_enable}, 16'h0000);
        for (int i = 0; i < 3; i++)
            host.wr(cst_pkg::OFF_TABLE, 16'h0A00 + 16'(i));
        gray_level = 9'h000;
        host.wr(cst_pkg::OFF_CTRL_B, 16'hB000);
        for (int i = 0; i < 3; i++)
            tc(9'(i), 12'hA00 + 12'(i));
        chk({15'h0, tonemap_enable}, 16'h0001);
        $display("test table done");
        srst = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 srst = 1'b0;
        chk({4'h0, threshold_out}, 16'h0000);
        chk({15'h0, tonemap_enable}, 16'h0000);
        clk_en = 1'b0;
        host.wr(cst_pkg::OFF_TABLE, 16'h0FFF);
        clk_en = 1'b1;
        host.wr(cst_pkg::OFF_TABLE, 16'h0B11);
        host.wr(cst_pkg::OFF_CTRL_B, 16'h2000);
        tc(9'h000, 12'hB11);
        $display("test restart done");
        complete_run();
    end
endmodule
